// >>> twi_supervisor_defs.vh
// Constants for the two-wire slave front end and supply-reset supervisor
`ifndef TWI_SUPERVISOR_DEFS_VH
`define TWI_SUPERVISOR_DEFS_VH
`define TGT_ARRAY       3'h0
`define TGT_CONTROL     3'h2
`define TGT_POT         3'h7
`define ADDR_TYPE_MSB   7
`define ADDR_TYPE_LSB   4
`define ADDR_TGT_MSB    3
`define ADDR_TGT_LSB    1
`define ADDR_RW_BIT     0
`define CLK_PERIOD_NS   10
`define NV_WRITE_MS     5
`define NV_WRITE_CYC    ((`NV_WRITE_MS * 1000000) / `CLK_PERIOD_NS)
`define HOLD0_MS        50
`define HOLD1_MS        100
`define HOLD2_MS        200
`define HOLD3_MS        300
`define MS_TO_CYC(m)    (((m) * 1000000) / `CLK_PERIOD_NS)
`endif

// >>> reset_hold_timer.v
// Supply-reset hold timer: reset output held for a selectable time after causes clear
`timescale 1ns/1ps
module reset_hold_timer #(
  parameter CW = 26
) (
  input  wire          clk,
  input  wire          reset_n,
  input  wire          cause,
  input  wire [CW-1:0] hold_cycles,
  output reg           reset_out
);
  reg [CW-1:0] count_r;

  // Power-up counts as a cause: output starts high and the hold restarts on any cause
  always @(posedge clk) begin
    if (!reset_n) begin
      count_r   <= {CW{1'b0}};
      reset_out <= 1'b1;
    end else if (cause) begin
      count_r   <= {CW{1'b0}};
      reset_out <= 1'b1;
    end else if (reset_out) begin
      if (count_r >= hold_cycles - 1'b1) begin
        reset_out <= 1'b0;
      end else begin
        count_r <= count_r + 1'b1;
      end
    end
  end
endmodule

// >>> twi_supervisor.v
// Two-wire slave front end with write-protect gating and supply-reset supervisor
`timescale 1ns/1ps
`include "twi_supervisor_defs.vh"
module twi_supervisor #(
  parameter [3:0] DEV_TYPE   = 4'h5, // Arbitrary device type code
  parameter       NV_CYCLES  = `NV_WRITE_CYC,
  parameter       HOLD0_CYC  = `MS_TO_CYC(`HOLD0_MS),
  parameter       HOLD1_CYC  = `MS_TO_CYC(`HOLD1_MS),
  parameter       HOLD2_CYC  = `MS_TO_CYC(`HOLD2_MS),
  parameter       HOLD3_CYC  = `MS_TO_CYC(`HOLD3_MS)
) (
  input  wire       CLK,
  input  wire       RESET_N,
  input  wire       SCL_IN,
  input  wire       SDA_IN,
  output reg        SDA_OUT,
  output reg        SDA_OE,
  input  wire       WRITE_GUARD,
  input  wire       WRITE_ENABLE_LATCH,
  input  wire [1:0] LOCK_FIELD,
  input  wire       NV_WRITE_TYPE,
  input  wire [7:0] TX_DATA,
  output reg        TX_TAKEN,
  output reg  [7:0] RX_DATA,
  output reg        RX_VALID,
  output reg        RX_FIRST,
  output reg  [2:0] TARGET,
  output reg        CMD_DONE,
  output reg        WRITE_REFUSED,
  output reg        NV_BUSY,
  input  wire       MANUAL_RESET_IN,
  input  wire       SUPPLY_LOW,
  input  wire       RESET_DELAY_SELECT_HI,
  input  wire       RESET_DELAY_SELECT_LO,
  input  wire       MONITOR_A_ABOVE,
  input  wire       MONITOR_B_ABOVE,
  output wire       SUPPLY_RESET_OUT,
  output reg        MONITOR_A_OUT,
  output reg        MONITOR_B_OUT
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_ADDR  = 3'h1;
  localparam [2:0] S_WACK  = 3'h2;
  localparam [2:0] S_WDAT  = 3'h3;
  localparam [2:0] S_RDAT  = 3'h4;
  localparam [2:0] S_RACK  = 3'h5;
  localparam [2:0] S_IGNR  = 3'h6;

  reg        scl_r;
  reg        sda_r;
  reg  [2:0] state_r;
  reg  [3:0] bit_r;
  reg  [7:0] shift_r;
  reg        ack_r;
  reg        read_r;
  reg        first_r;
  reg        wr_ok_r;
  reg        nv_pend_r;
  reg [31:0] nv_cnt_r;
  reg  [7:0] tx_r;

  wire scl_rise = SCL_IN & ~scl_r;
  wire scl_fall = ~SCL_IN & scl_r;
  // Both lines sampled the same clock, so the start/stop tests see one consistent view
  wire start_ev = scl_r & SCL_IN & sda_r & ~SDA_IN;
  wire stop_ev  = scl_r & SCL_IN & ~sda_r & SDA_IN;
  wire [7:0] rx_byte = {shift_r[6:0], SDA_IN};

  // Write permission for a decoded target; the array and potentiometers need the latch
  function write_allowed;
    input [2:0] tgt;
    input       nv;
    input       guard;
    input [1:0] lock;
    input       latch;
    begin
      // A low guard, which is also its unconnected level, leaves writes open
      write_allowed = 1'b1;
      if ((tgt == `TGT_ARRAY || tgt == `TGT_POT) && !latch) begin
        write_allowed = 1'b0;
      end else if (guard && nv) begin
        write_allowed = 1'b0;
      end else if (guard && lock != 2'b00) begin
        write_allowed = 1'b0;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  // Pure slave: nothing here ever drives the clock line or begins a transfer.
  always @(posedge CLK) begin
    if (!RESET_N) begin
      scl_r         <= 1'b1;
      sda_r         <= 1'b1;
      state_r       <= S_IDLE;
      bit_r         <= 4'h0;
      shift_r       <= 8'h00;
      ack_r         <= 1'b0;
      read_r        <= 1'b0;
      first_r       <= 1'b0;
      wr_ok_r       <= 1'b0;
      tx_r          <= 8'h00;
      SDA_OUT       <= 1'b0;
      SDA_OE        <= 1'b0;
      TX_TAKEN      <= 1'b0;
      RX_DATA       <= 8'h00;
      RX_VALID      <= 1'b0;
      RX_FIRST      <= 1'b0;
      TARGET        <= 3'h0;
      CMD_DONE      <= 1'b0;
      WRITE_REFUSED <= 1'b0;
    end else begin
      scl_r         <= SCL_IN;
      sda_r         <= SDA_IN;
      TX_TAKEN      <= 1'b0;
      RX_VALID      <= 1'b0;
      RX_FIRST      <= 1'b0;
      CMD_DONE      <= 1'b0;
      WRITE_REFUSED <= 1'b0;
      if (start_ev) begin
        state_r <= S_ADDR;
        bit_r   <= 4'h0;
        SDA_OE  <= 1'b0;
        first_r <= 1'b1;
      end else if (stop_ev) begin
        state_r  <= S_IDLE;
        SDA_OE   <= 1'b0;
        CMD_DONE <= (state_r != S_IDLE);
      end else if (scl_rise) begin
        // Sampling on the rising edge; drive changes wait for the falling edge.
        case (state_r)
          S_ADDR, S_WDAT: begin
            shift_r <= rx_byte;
            bit_r   <= bit_r + 4'h1;
            if (bit_r == 4'h7) begin
              bit_r <= 4'h0;
              if (state_r == S_ADDR) begin
                read_r <= rx_byte[`ADDR_RW_BIT];
                TARGET <= rx_byte[`ADDR_TGT_MSB:`ADDR_TGT_LSB];
                // Busy polling: no answer while the nonvolatile cycle runs.
                ack_r  <= (rx_byte[`ADDR_TYPE_MSB:`ADDR_TYPE_LSB] == DEV_TYPE)
                          && !nv_pend_r;
                wr_ok_r <= 1'b1;
              end else begin
                RX_DATA  <= rx_byte;
                RX_FIRST <= first_r;
                first_r  <= 1'b0;
                if (write_allowed(TARGET, NV_WRITE_TYPE, WRITE_GUARD,
                                  LOCK_FIELD, WRITE_ENABLE_LATCH) && wr_ok_r) begin
                  RX_VALID <= 1'b1;
                end else begin
                  WRITE_REFUSED <= 1'b1;
                  wr_ok_r       <= 1'b0;
                end
                ack_r <= 1'b1;
              end
              state_r <= S_WACK;
            end
          end
          S_WACK: begin
            if (!ack_r) begin
              state_r <= S_IGNR;
            end else if (read_r) begin
              state_r <= S_RDAT;
            end else begin
              state_r <= S_WDAT;
            end
          end
          S_RDAT: begin
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'h7) begin
              bit_r   <= 4'h0;
              state_r <= S_RACK;
            end
          end
          S_RACK: begin
            // Master acknowledge continues; no acknowledge ends sending.
            state_r <= SDA_IN ? S_IGNR : S_RDAT;
          end
          default: begin
            state_r <= state_r;
          end
        endcase
      end else if (scl_fall) begin
        case (state_r)
          S_WACK: begin
            SDA_OUT <= 1'b0;
            SDA_OE  <= ack_r;
          end
          S_RDAT: begin
            if (bit_r == 4'h0) begin
              tx_r     <= {TX_DATA[6:0], 1'b0};
              SDA_OUT  <= TX_DATA[7];
              SDA_OE   <= ~TX_DATA[7];
              TX_TAKEN <= 1'b1;
            end else begin
              tx_r    <= {tx_r[6:0], 1'b0};
              SDA_OUT <= tx_r[7];
              SDA_OE  <= ~tx_r[7];
            end
          end
          default: begin
            SDA_OE <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Nonvolatile write cycle
  // ----------------------------------------------------------------
  // Begins on the stop that closes an accepted nonvolatile write
  always @(posedge CLK) begin
    if (!RESET_N) begin
      nv_pend_r <= 1'b0;
      nv_cnt_r  <= 32'h0;
      NV_BUSY   <= 1'b0;
    end else if (stop_ev && state_r == S_WDAT && !read_r && wr_ok_r && !first_r
                 && NV_WRITE_TYPE && !WRITE_GUARD) begin
      nv_pend_r <= 1'b1;
      nv_cnt_r  <= 32'h0;
      NV_BUSY   <= 1'b1;
    end else if (nv_pend_r) begin
      if (nv_cnt_r >= NV_CYCLES - 1) begin
        nv_pend_r <= 1'b0;
        NV_BUSY   <= 1'b0;
      end else begin
        nv_cnt_r <= nv_cnt_r + 32'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Supervisor outputs
  // ----------------------------------------------------------------
  reg [25:0] hold_sel;
  always @* begin
    case ({RESET_DELAY_SELECT_HI, RESET_DELAY_SELECT_LO})
      2'b00:   hold_sel = HOLD0_CYC[25:0];
      2'b01:   hold_sel = HOLD1_CYC[25:0];
      2'b10:   hold_sel = HOLD2_CYC[25:0];
      default: hold_sel = HOLD3_CYC[25:0];
    endcase
  end

  // Monitors pass straight through one flop; no filtering is added.
  always @(posedge CLK) begin
    if (!RESET_N) begin
      MONITOR_A_OUT <= 1'b0;
      MONITOR_B_OUT <= 1'b0;
    end else begin
      MONITOR_A_OUT <= MONITOR_A_ABOVE;
      MONITOR_B_OUT <= MONITOR_B_ABOVE;
    end
  end

  reset_hold_timer #(
    .CW (26)
  ) u_hold (
    .clk         (CLK),
    .reset_n     (RESET_N),
    .cause       (MANUAL_RESET_IN | SUPPLY_LOW),
    .hold_cycles (hold_sel),
    .reset_out   (SUPPLY_RESET_OUT)
  );
endmodule

// >>> twi_supervisor_props.sv
// Port-level checks for the two-wire slave and reset supervisor
`timescale 1ns/1ps
module twi_supervisor_props (
  input wire       CLK,
  input wire       RESET_N,
  input wire       SCL_IN,
  input wire       SDA_IN,
  input wire       SDA_OE,
  input wire       WRITE_GUARD,
  input wire       WRITE_ENABLE_LATCH,
  input wire [1:0] LOCK_FIELD,
  input wire       NV_WRITE_TYPE,
  input wire       RX_VALID,
  input wire       TX_TAKEN,
  input wire [2:0] TARGET,
  input wire       CMD_DONE,
  input wire       NV_BUSY,
  input wire       MANUAL_RESET_IN,
  input wire       MONITOR_A_ABOVE,
  input wire       SUPPLY_RESET_OUT,
  input wire       MONITOR_A_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  oe_low_scl_a: assert property ($changed(SDA_OE) |-> !$past(SCL_IN))
    else $error("data drive moved with clock high");
  stop_release_a: assert property (
    SCL_IN && $past(SCL_IN) && $rose(SDA_IN) |-> ##[1:3] !SDA_OE)
    else $error("drive kept after stop");
  latch_gate_a: assert property (
    RX_VALID && (TARGET == 3'h0 || TARGET == 3'h7) |-> WRITE_ENABLE_LATCH)
    else $error("write accepted without latch");
  guard_nv_a: assert property (RX_VALID |-> !(WRITE_GUARD && NV_WRITE_TYPE))
    else $error("nonvolatile write under guard");
  lock_gate_a: assert property (RX_VALID |-> !(WRITE_GUARD && LOCK_FIELD != 2'h0))
    else $error("write under guard and lock");
  busy_nack_a: assert property (NV_BUSY |-> !$rose(SDA_OE))
    else $error("acknowledge while busy");
  manual_reset_a: assert property (MANUAL_RESET_IN |-> ##[0:2] SUPPLY_RESET_OUT)
    else $error("manual reset ignored");
  monitor_follow_a: assert property (
    $past(RESET_N) |-> MONITOR_A_OUT == $past(MONITOR_A_ABOVE))
    else $error("monitor output lags");
  done_on_stop_a: assert property ($rose(CMD_DONE) |-> SCL_IN)
    else $error("command end without stop");
  load_low_a: assert property ($rose(TX_TAKEN) |-> !SCL_IN)
    else $error("read byte loaded with clock high");
  cover property (RX_VALID);
  cover property (TX_TAKEN);
  cover property (NV_BUSY);
endmodule
bind twi_supervisor twi_supervisor_props chk (.CLK(CLK), .RESET_N(RESET_N), .SCL_IN(SCL_IN),
  .SDA_IN(SDA_IN), .SDA_OE(SDA_OE), .WRITE_GUARD(WRITE_GUARD), .LOCK_FIELD(LOCK_FIELD),
  .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .NV_WRITE_TYPE(NV_WRITE_TYPE), .RX_VALID(RX_VALID),
  .TX_TAKEN(TX_TAKEN), .TARGET(TARGET), .CMD_DONE(CMD_DONE), .NV_BUSY(NV_BUSY),
  .MANUAL_RESET_IN(MANUAL_RESET_IN), .MONITOR_A_ABOVE(MONITOR_A_ABOVE),
  .SUPPLY_RESET_OUT(SUPPLY_RESET_OUT), .MONITOR_A_OUT(MONITOR_A_OUT));

// >>> twi_master_model.sv
// Two-wire bus master model: owns the serial clock, open-drain data
`timescale 1ns/1ps
module twi_master_model (
  input  wire clk,
  input  wire sda,
  output reg  scl,
  output reg  sda_o
);
  reg r;
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  // Data moves a third of a bit after the clock falls, never with it high except in start and stop
  task half;
    repeat (6) @(negedge clk);
  endtask
  task start;
    begin
      sda_o = 1'b1;
      half;
      scl = 1'b1;
      half;
      sda_o = 1'b0;
      half;
      scl = 1'b0;
      half;
    end
  endtask
  // Only called once the slave has let go of the data line
  task stop;
    begin
      sda_o = 1'b0;
      half;
      scl = 1'b1;
      half;
      sda_o = 1'b1;
      half;
    end
  endtask
  task bitx(input b, output rb);
    begin
      sda_o = b;
      half;
      scl = 1'b1;
      half;
      rb = sda;
      scl = 1'b0;
      half;
    end
  endtask
  task wbyte(input [7:0] d, output ack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bitx(d[i], r);
      bitx(1'b1, r);
      ack = !r;
    end
  endtask
  task rbyte(input ack, output [7:0] d);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bitx(1'b1, d[i]);
      bitx(!ack, r);
    end
  endtask
endmodule

// >>> twi_supervisor_tb.sv
// Self-checking testbench for the two-wire slave and reset supervisor
`timescale 1ns/1ps
module twi_supervisor_tb;
  localparam [3:0] TYP = 4'h9; // Arbitrary device type code
  localparam NVC = 400;
  reg CLK = 1'b0, RESET_N = 1'b0, guard = 1'b0, latch = 1'b0, nvw = 1'b0, mr = 1'b0;
  reg dhi = 1'b0, dlo = 1'b0, sl = 1'b0, ma = 1'b0, mb = 1'b0, ack;
  reg [1:0] lock = 2'h0;
  reg [7:0] txd = 8'h3c, rxd, d;
  reg [4:0] flg = 5'h00;
  integer n_errors = 0, n_checks = 0;
  wire scl, m_sda, sda_out, sda_oe, rx_v, refd, taken, done, busy, rst_o, mao, mbo, rx_f;
  wire [7:0] rx_data;
  wire [2:0] tgt;
  wire sda = m_sda & (sda_oe ? sda_out : 1'b1);
  always #5 CLK = ~CLK;
  twi_master_model m (.clk(CLK), .sda(sda), .scl(scl), .sda_o(m_sda));
  twi_supervisor #(.DEV_TYPE(TYP), .NV_CYCLES(NVC), .HOLD0_CYC(20), .HOLD1_CYC(40),
    .HOLD2_CYC(80), .HOLD3_CYC(120)) dut (.CLK(CLK), .RESET_N(RESET_N), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .WRITE_GUARD(guard), .TX_DATA(txd),
    .WRITE_ENABLE_LATCH(latch), .LOCK_FIELD(lock), .NV_WRITE_TYPE(nvw), .TX_TAKEN(taken),
    .RX_DATA(rx_data), .RX_VALID(rx_v), .RX_FIRST(rx_f), .TARGET(tgt), .CMD_DONE(done),
    .WRITE_REFUSED(refd), .NV_BUSY(busy), .MANUAL_RESET_IN(mr), .SUPPLY_LOW(sl),
    .RESET_DELAY_SELECT_HI(dhi), .RESET_DELAY_SELECT_LO(dlo), .MONITOR_A_ABOVE(ma),
    .MONITOR_B_ABOVE(mb), .SUPPLY_RESET_OUT(rst_o), .MONITOR_A_OUT(mao), .MONITOR_B_OUT(mbo));
  // Pulses are caught here so a task can judge them after the stop
  always @(posedge CLK) begin
    flg <= flg | {rx_f, taken, done, refd, rx_v};
    if (rx_v) rxd <= rx_data;
  end
  always @(negedge CLK) if (taken) txd <= ~txd;
  task check(input [7:0] seen, input [7:0] exp, input [95:0] what);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] dat, input ea, input erx, input eref);
    begin
      @(negedge CLK) flg = 5'h00;
      m.start;
      m.wbyte(a, ack);
      check(ack, ea, "addr ack");
      if (ack) m.wbyte(dat, ack);
      if (ea) check(ack, 1'b1, "data ack");
      m.stop;
      check(flg[0], erx, "accepted");
      check(flg[1], eref, "refused");
      check(flg[2], 1'b1, "cmd done");
      check(flg[4], ea, "first byte");
      check(tgt, a[3:1], "target");
      if (erx) check(rxd, dat, "data");
    end
  endtask
  // Mode bits: guard, lock field, latch, nonvolatile, expect accept
  task prot(input [5:0] c, input [2:0] t);
    begin
      {guard, lock, latch, nvw} = c[5:1];
      wr({TYP, t, 1'b0}, 8'h5a ^ {5'h0, t}, 1'b1, c[0], !c[0]);
    end
  endtask
  task t_read;
    begin
      @(negedge CLK) flg = 5'h00;
      m.start;
      m.wbyte({TYP, 3'h2, 1'b1}, ack);
      check(ack, 1'b1, "read addr");
      m.rbyte(1'b1, d);
      check(d, 8'h3c, "read 1");
      m.rbyte(1'b0, d);
      check(d, 8'hc3, "read 2");
      check(flg[3], 1'b1, "tx taken");
      check(sda_oe, 1'b0, "after nack");
      m.stop;
      check(sda_oe, 1'b0, "standby");
      $display("test read done");
    end
  endtask
  task t_nv;
    begin
      {guard, lock, latch, nvw} = 5'b0_00_1_1;
      wr({TYP, 3'h0, 1'b0}, 8'h77, 1'b1, 1'b1, 1'b0);
      check(busy, 1'b1, "nv busy");
      wr({TYP, 3'h0, 1'b1}, 8'h00, 1'b0, 1'b0, 1'b0);
      nvw = 1'b0;
      repeat (NVC) @(negedge CLK);
      wr({TYP, 3'h2, 1'b0}, 8'h01, 1'b1, 1'b1, 1'b0);
      $display("test poll done");
    end
  endtask
  task t_sup;
    begin
      {dhi, dlo, ma, mr} = 4'hf;
      repeat (3) @(negedge CLK);
      check(rst_o, 1'b1, "mr on");
      check({mbo, mao}, 2'h1, "monitors");
      {mr, mb} = 2'h1;
      repeat (118) @(negedge CLK);
      check({mbo, rst_o}, 2'h3, "hold 3");
      repeat (4) @(negedge CLK);
      check(rst_o, 1'b0, "hold 3 end");
      sl = 1'b1;
      repeat (3) @(negedge CLK);
      check(rst_o, 1'b1, "supply low");
      // Select 1, then a short manual pulse part way through must restart the hold
      {dhi, dlo, sl} = 3'h2;
      repeat (20) @(negedge CLK);
      mr = 1'b1;
      @(negedge CLK) mr = 1'b0;
      repeat (30) @(negedge CLK);
      check(rst_o, 1'b1, "restart");
      repeat (12) @(negedge CLK);
      check(rst_o, 1'b0, "hold 1 end");
      {dhi, dlo, mr} = 3'h5;
      @(negedge CLK) mr = 1'b0;
      repeat (78) @(negedge CLK);
      check(rst_o, 1'b1, "hold 2");
      repeat (4) @(negedge CLK);
      check(rst_o, 1'b0, "hold 2 end");
      $display("test supervisor done");
    end
  endtask
  initial begin
    #400000;
    n_errors = n_errors + 1;
    end_of_test;
  end
  initial begin
    repeat (3) @(negedge CLK);
    check({sda_oe, rst_o}, 2'h1, "in reset");
    RESET_N = 1'b1;
    repeat (18) @(negedge CLK);
    check({sda_oe, rst_o}, 2'h1, "hold 0");
    repeat (4) @(negedge CLK);
    check(rst_o, 1'b0, "hold 0 end");
    wr({4'h3, 3'h7, 1'b0}, 8'h11, 1'b0, 1'b0, 1'b0);
    prot(6'b0_00_1_0_1, 3'h7);
    prot(6'b0_00_0_0_0, 3'h7);
    prot(6'b1_01_1_0_0, 3'h7);
    prot(6'b1_00_1_0_1, 3'h7);
    prot(6'b1_00_1_1_0, 3'h0);
    prot(6'b0_00_0_0_1, 3'h2);
    $display("test protect done");
    t_read;
    t_nv;
    t_sup;
    end_of_test;
  end
endmodule
